// file: core/urf_pkg.sv
// Purpose: shared constants for the flow-controlled serial link
// Assumes: 40 MHz core clock, 8N1 framing
// Notes: baud divisor is a run-time input of each end
//
// What this block does
// - full duplex serial with flow control, up to 1 Mbps
// - request output, clear input, both low-active
// - idle data lines rest high
// - handshake low means asserted
// - host tx to device rx, crossed
// - host stops sending when request deasserted
// - standard asynchronous framing and handshake
// - transmit pin output, driven high at setup
// - receive pin input, pulled up
// - request pin output driven low at setup
// - clear pin input, wired straight to host request
// - baud range 1.2 to 1000 kbps
package urf_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int BAUD_MIN = 1200;
  localparam int BAUD_MAX = 1000000;
  localparam int DIV_W = 16;
  // bit period in core cycles for the range limits
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
  localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(CLK_HZ / 115200);
  localparam int DATA_W = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_START = 1'b0;
  localparam logic HS_ASSERT = 1'b0;
  localparam logic HS_DEASSERT = 1'b1;
  typedef enum {ST_IDLE, ST_START, ST_DATA, ST_STOP} urf_state_t;

  // clamp a requested divisor into the legal baud range
  function automatic logic [DIV_W-1:0] urf_clamp(input logic [DIV_W-1:0] d);
    if (d < DIV_MIN)
      urf_clamp = DIV_MIN;
    else if (d > DIV_MAX)
      urf_clamp = DIV_MAX;
    else
      urf_clamp = d;
  endfunction : urf_clamp
endpackage : urf_pkg

// file: core/urf_link_if.sv
`timescale 1ns/1ps
// Purpose: crossed point-to-point link between device and host
// Assumes: both ends on one clock
// Notes: pull-up on device rx modelled here, device cts wired straight to host request
interface urf_link_if;
  logic dev_tx;
  logic host_tx;
  logic dev_rts_n;
  logic host_rts_n;
  logic dev_tx_oe_n;
  logic host_tx_oe_n;
  logic dev_rx;
  logic dev_cts_n;
  // undriven rx reads high, cts always follows the host request
  assign dev_rx = host_tx_oe_n ? 1'b1 : host_tx;
  assign dev_cts_n = host_rts_n;

  modport device (output dev_tx, output dev_tx_oe_n, output dev_rts_n, input dev_rx, input dev_cts_n);
  modport host (output host_tx, output host_tx_oe_n, output host_rts_n, input dev_tx, input dev_rts_n);
endinterface : urf_link_if

// file: core/urf_host.sv
`timescale 1ns/1ps
// Purpose: host side serial port, transmits and receives 8N1
// Assumes: same framing and divisor as the device
// Notes: stops starting characters while device request is deasserted
module urf_host
  import urf_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  urf_link_if.host LINK,
  input wire logic [urf_pkg::DIV_W-1:0] BAUD_DIV,
  input wire logic [urf_pkg::DATA_W-1:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [urf_pkg::DATA_W-1:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_BUSY
);
  urf_state_t ts, next_ts, rs, next_rs;
  logic [DIV_W-1:0] tcnt, next_tcnt, rcnt, next_rcnt, div;
  logic [3:0] tbit, next_tbit, rbit, next_rbit;
  logic [DATA_W-1:0] tsh, next_tsh, rsh, next_rsh, rdat, next_rdat;
  logic tx, next_tx, rv, next_rv, rts, next_rts, trdy, next_trdy;
  logic ttick, rtick;

  assign div = urf_clamp(BAUD_DIV);
  assign ttick = (tcnt == div - DIV_W'(1));
  assign rtick = (rcnt == div - DIV_W'(1));

  always_comb
  begin
    next_ts = ts;
    next_tcnt = ttick ? '0 : tcnt + DIV_W'(1);
    next_tbit = tbit;
    next_tsh = tsh;
    next_tx = tx;
    case (ts)
      ST_IDLE:
      begin
        next_tcnt = '0;
        next_tx = LINE_IDLE;
        if (TX_VALID && LINK.dev_rts_n == HS_ASSERT)
        begin
          next_tsh = TX_DATA;
          next_tx = LINE_START;
          next_ts = ST_START;
        end
      end
      ST_START:
        if (ttick)
        begin
          next_tx = tsh[0];
          next_tbit = '0;
          next_ts = ST_DATA;
        end
      ST_DATA:
        if (ttick)
        begin
          next_tsh = tsh >> 1;
          if (tbit == LAST_BIT)
          begin
            next_tx = LINE_IDLE;
            next_ts = ST_STOP;
          end
          else
          begin
            next_tx = tsh[1];
            next_tbit = tbit + 4'h1;
          end
        end
      ST_STOP:
        if (ttick)
          next_ts = ST_IDLE;
      default:
        next_ts = ST_IDLE;
    endcase
    next_trdy = (next_ts == ST_IDLE);
  end

  always_comb
  begin
    next_rs = rs;
    next_rcnt = rtick ? '0 : rcnt + DIV_W'(1);
    next_rbit = rbit;
    next_rsh = rsh;
    next_rdat = rdat;
    next_rv = 1'b0;
    next_rts = RX_BUSY ? HS_DEASSERT : HS_ASSERT;
    case (rs)
      ST_IDLE:
      begin
        next_rcnt = '0;
        if (LINK.dev_tx == LINE_START)
          next_rs = ST_START;
      end
      ST_START:
        if (rcnt == (div >> 1))
        begin
          next_rcnt = '0;
          next_rbit = '0;
          next_rs = (LINK.dev_tx == LINE_START) ? ST_DATA : ST_IDLE;
        end
      ST_DATA:
        if (rtick)
        begin
          next_rsh = {LINK.dev_tx, rsh[DATA_W-1:1]};
          if (rbit == LAST_BIT)
            next_rs = ST_STOP;
          else
            next_rbit = rbit + 4'h1;
        end
      ST_STOP:
        if (rtick)
        begin
          if (LINK.dev_tx == LINE_IDLE)
          begin
            next_rdat = rsh;
            next_rv = 1'b1;
          end
          next_rs = ST_IDLE;
        end
      default:
        next_rs = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ts <= ST_IDLE;
      rs <= ST_IDLE;
      tcnt <= '0;
      rcnt <= '0;
      tbit <= '0;
      rbit <= '0;
      tsh <= '0;
      rsh <= '0;
      rdat <= '0;
      tx <= LINE_IDLE;
      rv <= 1'b0;
      rts <= HS_ASSERT;
      trdy <= 1'b1;
    end
    else
    begin
      ts <= next_ts;
      rs <= next_rs;
      tcnt <= next_tcnt;
      rcnt <= next_rcnt;
      tbit <= next_tbit;
      rbit <= next_rbit;
      tsh <= next_tsh;
      rsh <= next_rsh;
      rdat <= next_rdat;
      tx <= next_tx;
      rv <= next_rv;
      rts <= next_rts;
      trdy <= next_trdy;
    end
  end

  assign LINK.host_tx = tx;
  assign LINK.host_tx_oe_n = 1'b0;
  assign LINK.host_rts_n = rts;
  assign TX_READY = trdy;
  assign RX_DATA = rdat;
  assign RX_VALID = rv;
endmodule : urf_host

// file: core/urf_device.sv
`timescale 1ns/1ps
// Purpose: device side serial port with request/clear flow control
// Assumes: divisor given in core cycles per bit
// Notes: request deasserts while a received byte waits unread
module urf_device
  import urf_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  urf_link_if.device LINK,
  input wire logic [urf_pkg::DIV_W-1:0] BAUD_DIV,
  input wire logic [urf_pkg::DATA_W-1:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [urf_pkg::DATA_W-1:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_TAKE,
  output logic RX_OVERRUN
);
  urf_state_t ts, next_ts, rs, next_rs;
  logic [DIV_W-1:0] tcnt, next_tcnt, rcnt, next_rcnt, div;
  logic [3:0] tbit, next_tbit, rbit, next_rbit;
  logic [DATA_W-1:0] tsh, next_tsh, rsh, next_rsh, rdat, next_rdat;
  logic tx, next_tx, rv, next_rv, ovr, next_ovr, rts, next_rts, trdy, next_trdy;
  logic ttick, rtick;

  // divisor held inside 1.2..1000 kbps
  assign div = urf_clamp(BAUD_DIV);
  assign ttick = (tcnt == div - DIV_W'(1));
  assign rtick = (rcnt == div - DIV_W'(1));

  // --------------------------------
  // transmitter
  // --------------------------------
  always_comb
  begin
    next_ts = ts;
    next_tcnt = ttick ? '0 : tcnt + DIV_W'(1);
    next_tbit = tbit;
    next_tsh = tsh;
    next_tx = tx;
    next_trdy = 1'b0;
    case (ts)
      ST_IDLE:
      begin
        next_tcnt = '0;
        next_tx = LINE_IDLE;
        next_trdy = 1'b1;
        // offer stays pending while the clear line is deasserted
        if (TX_VALID && TX_READY && LINK.dev_cts_n == HS_ASSERT)
        begin
          next_tsh = TX_DATA;
          next_tx = LINE_START;
          next_ts = ST_START;
          next_trdy = 1'b0;
        end
      end
      ST_START:
        if (ttick)
        begin
          next_tx = tsh[0];
          next_tbit = '0;
          next_ts = ST_DATA;
        end
      ST_DATA:
        if (ttick)
        begin
          next_tsh = tsh >> 1;
          if (tbit == LAST_BIT)
          begin
            next_tx = LINE_IDLE;
            next_ts = ST_STOP;
            next_tbit = '0;
          end
          else
          begin
            next_tx = tsh[1];
            next_tbit = tbit + 4'h1;
          end
        end
      ST_STOP:
        if (ttick)
        begin
          next_ts = ST_IDLE;
          next_trdy = 1'b1;
        end
      default:
        next_ts = ST_IDLE;
    endcase
  end

  // --------------------------------
  // receiver
  // --------------------------------
  always_comb
  begin
    next_rs = rs;
    next_rcnt = rtick ? '0 : rcnt + DIV_W'(1);
    next_rbit = rbit;
    next_rsh = rsh;
    next_rdat = rdat;
    next_rv = rv & ~RX_TAKE;
    next_ovr = 1'b0;
    case (rs)
      ST_IDLE:
      begin
        next_rcnt = '0;
        if (LINK.dev_rx == LINE_START)
          next_rs = ST_START;
      end
      ST_START:
        if (rcnt == (div >> 1))
        begin
          next_rcnt = '0;
          next_rbit = '0;
          next_rs = (LINK.dev_rx == LINE_START) ? ST_DATA : ST_IDLE;
        end
      ST_DATA:
        if (rtick)
        begin
          next_rsh = {LINK.dev_rx, rsh[DATA_W-1:1]};
          if (rbit == LAST_BIT)
            next_rs = ST_STOP;
          else
            next_rbit = rbit + 4'h1;
        end
      ST_STOP:
        if (rtick)
        begin
          if (LINK.dev_rx == LINE_IDLE)
          begin
            // new byte wins over a same-cycle take
            next_ovr = rv & ~RX_TAKE;
            next_rdat = rsh;
            next_rv = 1'b1;
          end
          next_rs = ST_IDLE;
        end
      default:
        next_rs = ST_IDLE;
    endcase
    // ready for data while the holding register is free
    next_rts = next_rv ? HS_DEASSERT : HS_ASSERT;
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ts <= ST_IDLE;
      rs <= ST_IDLE;
      tcnt <= '0;
      rcnt <= '0;
      tbit <= '0;
      rbit <= '0;
      tsh <= '0;
      rsh <= '0;
      rdat <= '0;
      tx <= LINE_IDLE;
      rv <= 1'b0;
      ovr <= 1'b0;
      rts <= HS_ASSERT;
      trdy <= 1'b1;
    end
    else
    begin
      ts <= next_ts;
      rs <= next_rs;
      tcnt <= next_tcnt;
      rcnt <= next_rcnt;
      tbit <= next_tbit;
      rbit <= next_rbit;
      tsh <= next_tsh;
      rsh <= next_rsh;
      rdat <= next_rdat;
      tx <= next_tx;
      rv <= next_rv;
      ovr <= next_ovr;
      rts <= next_rts;
      trdy <= next_trdy;
    end
  end

  assign LINK.dev_tx = tx;
  assign LINK.dev_tx_oe_n = 1'b0;
  assign LINK.dev_rts_n = rts;
  assign TX_READY = trdy;
  assign RX_DATA = rdat;
  assign RX_VALID = rv;
  assign RX_OVERRUN = ovr;
endmodule : urf_device

// file: verif/urf_assertions.sv
// Purpose: link checks for the serial pair
// Assumes: one clock, async high reset
// Notes: sees only the link signals
`timescale 1ns/1ps
module urf_assertions
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic dev_tx,
  input wire logic host_tx,
  input wire logic dev_rts_n,
  input wire logic host_rts_n,
  input wire logic dev_tx_oe_n,
  input wire logic host_tx_oe_n,
  input wire logic dev_rx,
  input wire logic dev_cts_n
);
  // ----------------------------------------
  // link properties
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  a_dev_drives: assert property (!dev_tx_oe_n) else $error("dev tx undriven");
  a_host_drives: assert property (!host_tx_oe_n) else $error("host tx undriven");
  a_rx_crossed: assert property (dev_rx == host_tx) else $error("rx not crossed");
  a_cts_crossed: assert property (dev_cts_n == host_rts_n) else $error("cts not crossed");
  a_host_halts: assert property ($fell(host_tx) |-> !$past(dev_rts_n)) else $error("host sent on stop");
  a_dev_bit_hold: assert property ($changed(dev_tx) |=> $stable(dev_tx) [*8]) else $error("dev bit short");
  a_host_bit_hold: assert property ($changed(host_tx) |=> $stable(host_tx) [*8]) else $error("host bit short");
  a_rts_at_stop: assert property ($rose(dev_rts_n) |-> $past(dev_rx)) else $error("rts off stop");
  a_reset_idle: assert property ($fell(SYS_RST) |-> dev_tx && host_tx && !dev_rts_n) else $error("bad idle");
endmodule : urf_assertions

// file: verif/tb.sv
// Purpose: self-checking bench for the device and host pair
// Assumes: both ends share one divisor
// Notes: frames are sampled at mid bit on the wire
`timescale 1ns/1ps
module tb;
  import urf_pkg::*;
  logic CORE_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [DIV_W-1:0] div = 16'h0028;
  logic [DATA_W-1:0] d_txd = 8'h00, h_txd = 8'h00, d_rxd, h_rxd, h_got;
  logic d_txv = 1'b0, h_txv = 1'b0, d_take = 1'b0, h_busy = 1'b0, sel = 1'b0;
  logic d_rdy, h_rdy, d_rxv, h_rxv, d_ovr;
  logic ovr_seen = 1'b0;
  logic [7:0] pat [2] = '{8'ha5, 8'h3c};
  int err_total = 0, checked = 0, h_cnt = 0;
  urf_link_if link_inst();
  wire line = sel ? link_inst.host_tx : link_inst.dev_tx;
  urf_device urf_device_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .LINK(link_inst), .BAUD_DIV(div),
    .TX_DATA(d_txd), .TX_VALID(d_txv), .TX_READY(d_rdy), .RX_DATA(d_rxd), .RX_VALID(d_rxv), .RX_TAKE(d_take),
    .RX_OVERRUN(d_ovr));
  urf_host urf_host_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .LINK(link_inst), .BAUD_DIV(div),
    .TX_DATA(h_txd), .TX_VALID(h_txv), .TX_READY(h_rdy), .RX_DATA(h_rxd), .RX_VALID(h_rxv), .RX_BUSY(h_busy));
  urf_assertions urf_assertions_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .dev_tx(link_inst.dev_tx),
    .host_tx(link_inst.host_tx), .dev_rts_n(link_inst.dev_rts_n), .host_rts_n(link_inst.host_rts_n),
    .dev_tx_oe_n(link_inst.dev_tx_oe_n), .host_tx_oe_n(link_inst.host_tx_oe_n), .dev_rx(link_inst.dev_rx),
    .dev_cts_n(link_inst.dev_cts_n));
  initial
  begin
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  // host receive pulses are caught here
  always @(posedge CORE_CLK)
    if (h_rxv === 1'b1)
    begin
      h_got <= h_rxd;
      h_cnt <= h_cnt + 1;
    end
  // any overrun pulse is remembered
  always @(posedge CORE_CLK)
    if (d_ovr === 1'b1)
      ovr_seen <= 1'b1;
  // ----------------------------------------
  // bench tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #2;
  endtask : tick
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp, input string what);
    cmp8({7'h00, got}, {7'h00, exp}, what);
  endtask : cmp1
  task automatic send(input logic hs, input logic [7:0] b);
    int i;
    for (i = 0; i < 20000 && (hs ? h_rdy : d_rdy) !== 1'b1; i++)
      tick(1);
    if (hs)
    begin
      h_txd = b;
      h_txv = 1'b1;
    end
    else
    begin
      d_txd = b;
      d_txv = 1'b1;
    end
    tick(1);
    for (i = 0; i < 20000 && (hs ? h_rdy : d_rdy) !== 1'b0; i++)
      tick(1);
    cmp1(hs ? h_rdy : d_rdy, 1'b0, "offer taken");
    if (hs)
      h_txv = 1'b0;
    else
      d_txv = 1'b0;
  endtask : send
  // samples one frame at mid bit, period p cycles
  task automatic chk_frame(input logic s, input logic [7:0] exp, input int p);
    int i;
    sel = s;
    for (i = 0; i < 20000 && line !== 1'b0; i++)
      tick(1);
    tick(p / 2);
    cmp1(line, LINE_START, "start");
    for (i = 0; i < 8; i++)
    begin
      tick(p);
      cmp1(line, exp[i], "data");
    end
    tick(p);
    cmp1(line, LINE_IDLE, "stop");
  endtask : chk_frame
  task automatic wait_dv;
    int i;
    for (i = 0; i < 2000 && d_rxv !== 1'b1; i++)
      tick(1);
    cmp1(d_rxv, 1'b1, "rx wait");
  endtask : wait_dv
  task automatic take;
    d_take = 1'b1;
    tick(1);
    d_take = 1'b0;
  endtask : take
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    tick(8);
    SYS_RST = 1'b0;
    cmp1(link_inst.dev_tx, LINE_IDLE, "dev idle");
    cmp1(link_inst.host_tx, LINE_IDLE, "host idle");
    cmp1(link_inst.dev_rts_n, HS_ASSERT, "rts setup");
    cmp1(link_inst.dev_cts_n, HS_ASSERT, "cts setup");
    $display("test reset done");
    for (int k = 0; k < 2; k++)
    begin
      fork
        send(1'b0, pat[k]);
        chk_frame(1'b0, pat[k], 40);
      join
      tick(5);
      cmp8(h_got, pat[k], "host rx");
    end
    cmp8(8'(h_cnt), 8'h02, "host count");
    $display("test device to host done");
    fork
      send(1'b1, 8'h5a);
      chk_frame(1'b1, 8'h5a, 40);
    join
    wait_dv();
    cmp8(d_rxd, 8'h5a, "dev rx");
    cmp1(link_inst.dev_rts_n, HS_DEASSERT, "rts held");
    fork
      send(1'b1, 8'hc3);
      begin
        tick(120);
        cmp1(link_inst.host_tx, LINE_IDLE, "host waits");
        take();
        tick(1);
        cmp1(link_inst.dev_rts_n, HS_ASSERT, "rts freed");
      end
    join
    wait_dv();
    cmp8(d_rxd, 8'hc3, "dev rx2");
    take();
    $display("test host to device done");
    fork
      send(1'b0, 8'h0f);
      send(1'b1, 8'hf0);
    join
    wait_dv();
    tick(5);
    cmp8(h_got, 8'h0f, "duplex host");
    cmp8(d_rxd, 8'hf0, "duplex dev");
    take();
    $display("test duplex done");
    div = 16'h000a;
    fork
      send(1'b0, 8'h81);
      chk_frame(1'b0, 8'h81, 40);
    join
    tick(5);
    cmp8(h_got, 8'h81, "clamped rx");
    div = 16'h0028;
    $display("test clamp done");
    h_busy = 1'b1;
    tick(2);
    cmp1(link_inst.dev_cts_n, HS_DEASSERT, "cts off");
    fork
      send(1'b0, 8'h77);
      chk_frame(1'b0, 8'h77, 40);
      begin
        tick(480);
        cmp1(link_inst.dev_tx, LINE_IDLE, "dev held");
        cmp8(8'(h_cnt), 8'h04, "no rx");
        h_busy = 1'b0;
      end
    join
    tick(5);
    cmp8(h_got, 8'h77, "released rx");
    cmp1(ovr_seen, 1'b0, "no overrun");
    $display("test clear to send done");
    final_report();
  end
  initial
  begin
    tick(30000);
    err_total++;
    final_report();
  end
endmodule : tb
